// ### verilog/dwc_defines.svh
// constants for the dual wiper serial controller
`ifndef DWC_DEFINES_SVH
`define DWC_DEFINES_SVH

// fixed upper five bits of the slave address
`define DWC_ADDR_FIXED 5'h0b
// slave address byte layout
`define DWC_ADDR_HI_MSB 7
`define DWC_ADDR_HI_LSB 3
`define DWC_ADDR_PIN_HIGH_BIT 2
`define DWC_ADDR_PIN_LOW_BIT 1
`define DWC_RW_BIT 0
// instruction byte layout
`define DWC_INST_SEL_BIT 7
`define DWC_INST_RS_BIT 6
`define DWC_INST_SD_BIT 5
`define DWC_INST_O2_BIT 4
`define DWC_INST_O1_BIT 3
// wiper code width and midscale preset
`define DWC_CODE_W 8
`define DWC_MIDSCALE 8'h80
// reset value of the instruction latch
`define DWC_INST_RESET 8'h00
// bit counter positions inside one nine-clock byte slot
`define DWC_LAST_BIT 4'h7
`define DWC_ACK_SLOT 4'h8
`define DWC_CNT_ZERO 4'h0
`define DWC_CNT_ONE 4'h1

`endif

// ### verilog/dwc_pkg.sv
// types shared by the dual wiper serial controller
package dwc_pkg;

	// wiper code, one of 256 tap positions
	typedef logic [7:0] dwc_code_t;

	// phase of the serial transfer as seen by the slave
	typedef enum logic [2:0] {
		PH_ADDR,
		PH_INST,
		PH_WDATA,
		PH_RDATA,
		PH_IDLE
	} dwc_phase_e;

endpackage : dwc_pkg

// ### verilog/dwc_sync2.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module dwc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;

endmodule : dwc_sync2

// ### verilog/dwc_stop_det.sv
// stop condition catcher: data rising while the bus clock is high
`timescale 1ns/1ps
module dwc_stop_det (
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic stop_o
);

	logic stop_r;
	logic clr_n;

	// cleared whenever the bus clock is low or the chip is in reset
	assign clr_n = rst_n_i & scl_i;

	// a rising data edge can only reach the set while the clock is high
	always_ff @(posedge sda_i or negedge clr_n) begin
		if (!clr_n) begin
			stop_r <= 1'b0;
		end else begin
			stop_r <= 1'b1;
		end
	end

	assign stop_o = stop_r;

endmodule : dwc_stop_det

// ### verilog/dwc_wiper_ctrl.sv
// dual wiper serial slave: link side on the bus clock, wiper state on ref_clk_i
`timescale 1ns/1ps
`include "dwc_defines.svh"
module dwc_wiper_ctrl (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_select_pin_low_i,
	input wire logic addr_select_pin_high_i,
	input wire logic shutdown_pin_n_i,
	output dwc_pkg::dwc_code_t wiper_code_first_o,
	output dwc_pkg::dwc_code_t wiper_code_second_o,
	output logic selected_channel_o,
	output logic shutdown_o,
	output logic logic_out_first_o,
	output logic logic_out_second_o
);
	import dwc_pkg::*;

	localparam int NUM_CH = 2;

	// link domain, clocked by the bus clock
	logic stop_seen;
	logic link_rst_n;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	dwc_phase_e phase_r;
	dwc_phase_e phase_nxt;
	logic [6:0] shift_r;
	logic ack_r;
	logic ack_nxt;
	logic rd_dir_r;
	logic [7:0] tx_r;
	logic oe_r;
	logic oe_nxt;
	logic [7:0] inst_hold_r;
	logic [7:0] data_hold_r;
	logic inst_tgl_r;
	logic data_tgl_r;
	logic [2:0] link_sync;
	logic rd_tgl_seen_r;
	dwc_code_t rd_word_link_r;
	logic [7:0] byte_in;
	logic byte_done;
	logic ack_slot;
	logic addr_hit;
	logic ad_high_s;
	logic ad_low_s;
	logic rd_tgl_s;
	logic inst_done;
	logic data_done;

	// reference domain
	logic rd_tgl_r;
	dwc_code_t rd_word_r;
	dwc_code_t rd_word_nxt;
	logic [2:0] ref_sync;
	logic inst_seen_r;
	logic data_seen_r;
	logic inst_evt;
	logic data_evt;
	logic shutdown_pin_n_req_s;
	logic sel_r;
	logic rs_r;
	logic sd_r;
	logic out_first_r;
	logic out_second_r;
	logic shutdown_r;
	logic sda_o_r;
	dwc_code_t wiper_code_register_r [NUM_CH];

	// stop ends every transfer and puts the link logic back to address phase
	dwc_stop_det u_stop (
		.rst_n_i(rst_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.stop_o(stop_seen)
	);

	// link state is held in reset by chip reset or a seen stop
	assign link_rst_n = rst_n_i & ~stop_seen;

	// address straps and the read word toggle, brought onto the bus clock
	dwc_sync2 #(
		.WIDTH(3)
	) u_link_sync (
		.clk_i(scl_i),
		.rst_n_i(rst_n_i),
		.d_i({rd_tgl_r, addr_select_pin_high_i, addr_select_pin_low_i}),
		.q_o(link_sync)
	);

	assign rd_tgl_s = link_sync[2];
	assign ad_high_s = link_sync[1];
	assign ad_low_s = link_sync[0];

	// incoming byte, MSB first, completed by the bit on the wire now
	assign byte_in = {shift_r, sda_i};
	assign byte_done = (bit_cnt_r == `DWC_LAST_BIT);
	assign ack_slot = (bit_cnt_r == `DWC_ACK_SLOT);

	// address decode: fixed prefix plus the two strap pins
	assign addr_hit = (byte_in[`DWC_ADDR_HI_MSB:`DWC_ADDR_HI_LSB] == `DWC_ADDR_FIXED)
		&& (byte_in[`DWC_ADDR_PIN_HIGH_BIT] == ad_high_s)
		&& (byte_in[`DWC_ADDR_PIN_LOW_BIT] == ad_low_s);

	// completed instruction and data bytes
	assign inst_done = (phase_r == PH_INST) && byte_done;
	assign data_done = (phase_r == PH_WDATA) && byte_done;

	// bit counter wraps after the ninth clock of each byte
	assign bit_cnt_nxt = ack_slot ? `DWC_CNT_ZERO : bit_cnt_r + `DWC_CNT_ONE;

	// phase sequencing and acknowledge decision
	always_comb begin
		phase_nxt = phase_r;
		ack_nxt = ack_r;
		unique case (phase_r)
			PH_ADDR: begin
				if (byte_done) begin
					ack_nxt = addr_hit;
				end
				if (ack_slot) begin
					ack_nxt = 1'b0;
					if (!ack_r) begin
						phase_nxt = PH_IDLE;
					end else if (rd_dir_r) begin
						phase_nxt = PH_RDATA;
					end else begin
						phase_nxt = PH_INST;
					end
				end
			end
			PH_INST: begin
				if (byte_done) begin
					ack_nxt = 1'b1;
				end
				if (ack_slot) begin
					ack_nxt = 1'b0;
					phase_nxt = PH_WDATA;
				end
			end
			PH_WDATA: begin
				if (byte_done) begin
					ack_nxt = 1'b1;
				end
				if (ack_slot) begin
					ack_nxt = 1'b0;
				end
			end
			PH_RDATA: begin
				ack_nxt = 1'b0;
				if (ack_slot) begin
					phase_nxt = sda_i ? PH_IDLE : PH_RDATA;
				end
			end
			PH_IDLE: begin
				ack_nxt = 1'b0;
			end
		endcase
	end

	// link state, sampled on the rising bus clock while data is stable
	always_ff @(posedge scl_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_r <= `DWC_CNT_ZERO;
			phase_r <= PH_ADDR;
			shift_r <= '0;
			ack_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			phase_r <= phase_nxt;
			shift_r <= byte_in[6:0];
			ack_r <= ack_nxt;
		end
	end

	// direction bit captured at the end of the address byte
	always_ff @(posedge scl_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rd_dir_r <= 1'b0;
		end else if ((phase_r == PH_ADDR) && byte_done) begin
			rd_dir_r <= byte_in[`DWC_RW_BIT];
		end
	end

	// transmit shifter: loaded at each read slot, shifted per bit
	always_ff @(posedge scl_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_r <= '0;
		end else if (ack_slot && (phase_nxt == PH_RDATA)) begin
			tx_r <= rd_word_link_r;
		end else if (phase_r == PH_RDATA) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// hand-off words and toggles survive a stop so no false edge is made
	always_ff @(posedge scl_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inst_hold_r <= `DWC_INST_RESET;
			data_hold_r <= `DWC_MIDSCALE;
			inst_tgl_r <= 1'b0;
			data_tgl_r <= 1'b0;
		end else begin
			if (inst_done) begin
				inst_hold_r <= byte_in;
				inst_tgl_r <= ~inst_tgl_r;
			end
			if (data_done) begin
				data_hold_r <= byte_in;
				data_tgl_r <= ~data_tgl_r;
			end
		end
	end

	// read word copied once its change toggle has settled on this side
	always_ff @(posedge scl_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_tgl_seen_r <= 1'b0;
			rd_word_link_r <= `DWC_MIDSCALE;
		end else if (rd_tgl_s != rd_tgl_seen_r) begin
			rd_tgl_seen_r <= rd_tgl_s;
			rd_word_link_r <= rd_word_r;
		end
	end

	// pull low for an ack or a zero read bit; release otherwise
	assign oe_nxt = (ack_slot && ack_r)
		|| ((phase_r == PH_RDATA) && !ack_slot && !tx_r[7]);

	// data pin is changed only on the falling bus clock
	always_ff @(negedge scl_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= oe_nxt;
		end
	end

	assign sda_oe_o = oe_r;

	// open-drain: the driven level is always low
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_o_r <= 1'b0;
		end else begin
			sda_o_r <= 1'b0;
		end
	end

	assign sda_o = sda_o_r;

	// reference domain: wiper, latch and shutdown state

	// byte toggles and the inverted shutdown pin, so a cleared stage means no request
	dwc_sync2 #(
		.WIDTH(3)
	) u_ref_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({inst_tgl_r, data_tgl_r, ~shutdown_pin_n_i}),
		.q_o(ref_sync)
	);

	assign shutdown_pin_n_req_s = ref_sync[0];
	assign inst_evt = ref_sync[2] ^ inst_seen_r;
	assign data_evt = ref_sync[1] ^ data_seen_r;

	// edge memory for the two byte toggles
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inst_seen_r <= 1'b0;
			data_seen_r <= 1'b0;
		end else begin
			inst_seen_r <= ref_sync[2];
			data_seen_r <= ref_sync[1];
		end
	end

	// instruction latches; low three bits are never looked at
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_r <= 1'b0;
			rs_r <= 1'b0;
			sd_r <= 1'b0;
			out_first_r <= 1'b0;
			out_second_r <= 1'b0;
		end else if (inst_evt) begin
			sel_r <= inst_hold_r[`DWC_INST_SEL_BIT];
			rs_r <= inst_hold_r[`DWC_INST_RS_BIT];
			sd_r <= inst_hold_r[`DWC_INST_SD_BIT];
			out_second_r <= inst_hold_r[`DWC_INST_O2_BIT];
			out_first_r <= inst_hold_r[`DWC_INST_O1_BIT];
		end
	end

	// one code register per channel, preset to midscale
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_wiper
		always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				wiper_code_register_r[ch] <= `DWC_MIDSCALE;
			end else if (inst_evt && inst_hold_r[`DWC_INST_RS_BIT]
				&& (inst_hold_r[`DWC_INST_SEL_BIT] == 1'(ch))) begin
				wiper_code_register_r[ch] <= `DWC_MIDSCALE;
			end else if (data_evt && (sel_r == 1'(ch))) begin
				wiper_code_register_r[ch] <= rs_r ? `DWC_MIDSCALE : data_hold_r;
			end
		end
	end

	// code of the last selected channel, offered to the read path
	assign rd_word_nxt = wiper_code_register_r[sel_r];

	// read word plus change toggle for the crossing to the bus clock
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_word_r <= `DWC_MIDSCALE;
			rd_tgl_r <= 1'b0;
		end else if (rd_word_nxt != rd_word_r) begin
			rd_word_r <= rd_word_nxt;
			rd_tgl_r <= ~rd_tgl_r;
		end
	end

	// shutdown from the bit or the low pin; codes stay untouched
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shutdown_r <= 1'b0;
		end else begin
			shutdown_r <= sd_r || shutdown_pin_n_req_s;
		end
	end

	// outputs straight from registers
	assign wiper_code_first_o = wiper_code_register_r[0];
	assign wiper_code_second_o = wiper_code_register_r[1];
	assign selected_channel_o = sel_r;
	assign shutdown_o = shutdown_r;
	assign logic_out_first_o = out_first_r;
	assign logic_out_second_o = out_second_r;

endmodule : dwc_wiper_ctrl

// ### dv/dwc_bus_master.sv
// behavioural two-wire bus master, clock parked high between frames
`timescale 1ns/1ps
module dwc_bus_master (
	output logic scl_o,
	output logic sda_pull_o,
	input wire logic sda_i
);
	// both lines released while idle
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// data falls while the clock is high
	task automatic start_bit();
		#3 sda_pull_o = 1'b1;
		#16 scl_o = 1'b0;
	endtask : start_bit
	// one clock slot, data moved only while the clock is low
	task automatic clock_bit(input logic b, output logic rd);
		#16 sda_pull_o = ~b;
		#16 scl_o = 1'b1;
		#16 rd = sda_i;
		#16 scl_o = 1'b0;
	endtask : clock_bit
	// byte out msb first, ack is high when the slave pulled low
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic rd;
		for (int i = 7; i >= 0; i--) clock_bit(d[i], rd);
		clock_bit(1'b1, rd);
		ack = ~rd;
	endtask : write_byte
	// byte in, last releases the line as no-acknowledge
	task automatic read_byte(input logic last, output logic [7:0] d);
		logic rd;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, rd);
			d[i] = rd;
		end
		clock_bit(last, rd);
	endtask : read_byte
	// data pulled low, clock rises, then data rises
	task automatic stop_bit();
		#16 sda_pull_o = 1'b1;
		#16 scl_o = 1'b1;
		#16 sda_pull_o = 1'b0;
		#16;
	endtask : stop_bit
endmodule : dwc_bus_master

// ### dv/dwc_wiper_ctrl_asserts.sv
// port checks for the dual wiper controller
`timescale 1ns/1ps
module dwc_wiper_ctrl_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic shutdown_pin_n_i,
	input wire dwc_pkg::dwc_code_t wiper_code_first_o,
	input wire dwc_pkg::dwc_code_t wiper_code_second_o,
	input wire logic selected_channel_o,
	input wire logic shutdown_o,
	input wire logic logic_out_first_o,
	input wire logic logic_out_second_o
);
	import dwc_pkg::*;
	logic [3:0] idle_cnt_r;
	logic [3:0] idle_cnt_nxt;
	logic oe_hi_r;
	// reference cycles with the bus clock parked high
	assign idle_cnt_nxt = !scl_i ? 4'h0 : (idle_cnt_r == 4'hf) ? idle_cnt_r : idle_cnt_r + 4'h1;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			idle_cnt_r <= 4'h0;
		else
			idle_cnt_r <= idle_cnt_nxt;
	// pull enable seen at each rising bus clock
	always_ff @(posedge scl_i or negedge rst_n_i)
		if (!rst_n_i)
			oe_hi_r <= 1'b0;
		else
			oe_hi_r <= sda_oe_o;
	sequence s_pin_low_run;
		!shutdown_pin_n_i [*6];
	endsequence
	sequence s_bus_parked;
		idle_cnt_r > 4'h9;
	endsequence
	a_reset_values: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> wiper_code_first_o == 8'h80 && wiper_code_second_o == 8'h80
		&& !logic_out_first_o && !logic_out_second_o && !selected_channel_o) else $error("bad reset state");
	a_reset_awake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) && shutdown_pin_n_i |=> !shutdown_o [*2]) else $error("false shutdown after reset");
	a_pin_shutdown: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_pin_low_run |-> shutdown_o) else $error("pin low but no shutdown");
	a_first_owner: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$changed(wiper_code_first_o) |-> !selected_channel_o && $stable(wiper_code_second_o))
		else $error("first code moved unselected");
	a_second_owner: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$changed(wiper_code_second_o) |-> selected_channel_o && $stable(wiper_code_first_o))
		else $error("second code moved unselected");
	a_oe_steady_high: assert property (@(negedge scl_i) disable iff (!rst_n_i)
		sda_oe_o == oe_hi_r) else $error("data pull moved while clock high");
	a_idle_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		idle_cnt_r > 4'h7 |-> !sda_oe_o) else $error("data held on idle bus");
	a_quiet_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_bus_parked |-> $stable(wiper_code_first_o) && $stable(wiper_code_second_o)
		&& $stable(logic_out_first_o) && $stable(logic_out_second_o)) else $error("state moved on idle bus");
	a_drive_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		sda_oe_o |-> !sda_o) else $error("data driven high");
endmodule : dwc_wiper_ctrl_asserts

// ### dv/tb_dwc_wiper_ctrl.sv
// self-checking bench for the dual wiper controller
`timescale 1ns/1ps
module tb_dwc_wiper_ctrl;
	import dwc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic pin_lo = 1'b0;
	logic pin_hi = 1'b1;
	logic sd_pin_n = 1'b1;
	logic scl, m_pull, sda_o, sda_oe_o, sel, sd, out_a, out_b, exp_sel, exp_sd, exp_o1, exp_o2;
	dwc_code_t code_a, code_b;
	dwc_code_t exp_code [2];
	logic [7:0] lfsr = 8'h5e;
	logic [7:0] inst, d0, d1;
	int num_errors = 0;
	int samples_checked = 0;
	wire logic sda_w;
	// open-drain data line with pull-up
	assign sda_w = ~(m_pull | (sda_oe_o & ~sda_o));
	always #5 ref_clk_i = ~ref_clk_i;
	dwc_bus_master master (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda_w));
	dwc_wiper_ctrl i_dwc_wiper_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_low_i(pin_lo), .addr_select_pin_high_i(pin_hi),
		.shutdown_pin_n_i(sd_pin_n), .wiper_code_first_o(code_a), .wiper_code_second_o(code_b),
		.selected_channel_o(sel), .shutdown_o(sd), .logic_out_first_o(out_a), .logic_out_second_o(out_b));
	// expectation helpers
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	function automatic logic [7:0] addr_of(input logic hi, input logic lo, input logic rw);
		return {5'h0b, hi, lo, rw};
	endfunction : addr_of
	function automatic dwc_code_t code_of(input logic [7:0] ins, input logic [7:0] d);
		return ins[6] ? 8'h80 : d;
	endfunction : code_of
	task automatic check_code(input dwc_code_t got, input dwc_code_t exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %0t code %h exp %h", $time, got, exp);
		end
	endtask : check_code
	task automatic check_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %0t flag %b exp %b", $time, got, exp);
		end
	endtask : check_flag
	task automatic check_all();
		check_code(code_a, exp_code[0]);
		check_code(code_b, exp_code[1]);
		check_flag(sel, exp_sel);
		check_flag(sd, exp_sd | ~sd_pin_n);
		check_flag(out_a, exp_o1);
		check_flag(out_b, exp_o2);
	endtask : check_all
	task automatic do_reset();
		rst_n_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		exp_code[0] = 8'h80;
		exp_code[1] = 8'h80;
		{exp_sel, exp_sd, exp_o1, exp_o2} = 4'h0;
		repeat (2) @(negedge ref_clk_i);
		check_all();
	endtask : do_reset
	task automatic do_write(input logic [7:0] addr, input logic [7:0] ins, input logic [7:0] a, input logic [7:0] b);
		logic ack;
		logic good;
		good = (addr == addr_of(pin_hi, pin_lo, 1'b0));
		master.start_bit();
		master.write_byte(addr, ack);
		check_flag(ack, good);
		if (good) begin
			master.write_byte(ins, ack);
			check_flag(ack, 1'b1);
			master.write_byte(a, ack);
			check_code(ins[7] ? code_b : code_a, code_of(ins, a));
			master.write_byte(b, ack);
			check_flag(ack, 1'b1);
			exp_sel = ins[7];
			exp_sd = ins[5];
			exp_o2 = ins[4];
			exp_o1 = ins[3];
			exp_code[ins[7]] = code_of(ins, b);
		end
		master.stop_bit();
		repeat (8) @(negedge ref_clk_i);
		check_all();
	endtask : do_write
	task automatic do_read();
		logic ack;
		logic [7:0] d;
		master.start_bit();
		master.write_byte(addr_of(pin_hi, pin_lo, 1'b1), ack);
		check_flag(ack, 1'b1);
		master.read_byte(1'b0, d);
		check_code(d, exp_code[exp_sel]);
		master.read_byte(1'b1, d);
		check_code(d, exp_code[exp_sel]);
		master.stop_bit();
		repeat (8) @(negedge ref_clk_i);
	endtask : do_read
	task automatic wrap_up();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// corner cases, then random transfers
	initial begin
		do_reset();
		do_write(addr_of(1'b1, 1'b0, 1'b0), 8'h60, 8'h33, 8'h5a);
		do_write(addr_of(1'b1, 1'b0, 1'b0), 8'h9f, 8'h00, 8'hff);
		do_read();
		for (int n = 0; n < 10; n++) begin
			lfsr = lfsr_next(lfsr);
			d0 = lfsr;
			lfsr = lfsr_next(lfsr);
			d1 = lfsr;
			lfsr = lfsr_next(lfsr);
			inst = lfsr;
			pin_hi = lfsr[0];
			pin_lo = lfsr[1];
			sd_pin_n = lfsr[2] | lfsr[4];
			do_write(addr_of(pin_hi, pin_lo, 1'b0), inst, d0, d1);
			do_read();
		end
		sd_pin_n = 1'b1;
		do_write({5'h0a, pin_hi, pin_lo, 1'b0}, 8'h40, 8'h11, 8'h22);
		do_write(addr_of(~pin_hi, pin_lo, 1'b0), 8'h40, 8'h11, 8'h22);
		do_reset();
		wrap_up();
	end
	// hang guard
	initial begin
		#500000;
		num_errors++;
		wrap_up();
	end
endmodule : tb_dwc_wiper_ctrl
bind dwc_wiper_ctrl dwc_wiper_ctrl_asserts i_asserts (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .shutdown_pin_n_i(shutdown_pin_n_i), .wiper_code_first_o(wiper_code_first_o),
	.wiper_code_second_o(wiper_code_second_o), .selected_channel_o(selected_channel_o), .shutdown_o(shutdown_o),
	.logic_out_first_o(logic_out_first_o), .logic_out_second_o(logic_out_second_o));
